// ==== logic/lcd_range_pkg.sv ====
// Purpose: shared constants and types for the display source / range / segment register bank
// Assumes: one 200 MHz clock, Avalon-MM word-aligned register map
// Notes: reset values for both digit-count variants are kept here
package lcd_range_pkg;
    // register byte addresses
    localparam logic [4:0] ADDR_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_OVER_THR = 5'h08;
    localparam logic [4:0] ADDR_UNDER_THR = 5'h0c;
    localparam logic [4:0] ADDR_DISP_WORD = 5'h10;
    localparam logic [4:0] ADDR_SEG_LOW = 5'h14;
    localparam logic [4:0] ADDR_SEG_MID = 5'h18;
    localparam logic [4:0] ADDR_SEG_HIGH = 5'h1c;
    // control field positions
    localparam int CTL_SEG_DIRECT = 0;
    localparam int CTL_HOST_SRC = 1;
    localparam int CTL_FREEZE = 2;
    localparam int CTL_PEAK = 3;
    // status field positions
    localparam int STS_OVER_FLAG = 0;
    localparam int STS_UNDER_FLAG = 1;
    localparam int STS_OVER_COND = 2;
    localparam int STS_UNDER_COND = 3;
    // reset values
    localparam logic [15:0] OVER_RST_45 = 16'h4e1f;
    localparam logic [15:0] OVER_RST_35 = 16'h7cf0;
    localparam logic [15:0] UNDER_RST_45 = 16'hb1e0;
    localparam logic [15:0] UNDER_RST_35 = 16'h8300;
    localparam logic [15:0] SEG16_RST = 16'h0000;
    localparam logic [7:0] SEG8_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // dash counts after the leading one
    localparam logic [2:0] DASHES_45 = 3'h4;
    localparam logic [2:0] DASHES_35 = 3'h3;
    // segment bits owned by digit 4 in the 40-bit lit vector {high, mid, low}
    localparam logic [39:0] DIGIT4_MASK = 40'h1f_e000_0000;
    localparam int LEAD_ONE_BIT = 37;

    typedef enum logic [2:0] {SRC_SEG, SRC_HOST, SRC_FREEZE, SRC_PEAK, SRC_LIVE} disp_src_t;

    // one completed conversion from the converter
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } conv_result_t;

    typedef struct packed {
        logic wait_q;
        logic [31:0] rdata;
        logic seg_dir;
        logic host_src;
        logic freeze;
        logic peak_mode;
        logic [15:0] over_thr;
        logic [15:0] under_thr;
        logic [15:0] disp_word;
        logic [15:0] seg_low;
        logic [15:0] seg_mid;
        logic [7:0] seg_high;
        logic over_flag;
        logic under_flag;
        logic over_cond;
        logic under_cond;
        disp_src_t src;
        logic [15:0] shown;
        logic over_dash;
        logic under_dash;
        logic [2:0] dashes;
        logic [39:0] seg_lit;
        logic lead_one5;
        logic lead_one4;
    } bank_state_t;
endpackage : lcd_range_pkg

// ==== logic/lcd_source_range_segment_regs.sv ====
// Purpose: display source selection, range limit checking and direct segment registers
// Assumes: conversion results and peak value arrive on this clock; host uses Avalon-MM
// Notes: every access answers with waitrequest low on the second cycle of the request
//
// Functional notes
// - source priority: segments, host, freeze, peak, live
// - segment mode drives segments, ignores display word
// - segment bit 0 lights, 1 blanks
// - over limit 16-bit signed, variant reset value
// - result above over limit latches over flag
// - over shows leading one plus dashes
// - under limit 16-bit signed, variant reset value
// - result below under limit sets under flag
// - under shows minus, one, plus dashes
// - segment low register layout, bit 0 zero
// - segment mid register layout, bit 0 zero
// - segment high register 8-bit layout
// - leading one drives digit 5 or 4
// - digit-4 bits inert on smaller variant
// - segment registers reset to zero
// - status read clears flags unless condition holds
// - freeze stops display word updating from results
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps

module lcd_source_range_segment_regs #(
    parameter bit FULL_DIGIT5 = 1'b1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire lcd_range_pkg::conv_result_t conv,
    input wire logic [15:0] peak_value,
    output lcd_range_pkg::disp_src_t display_source,
    output logic [15:0] display_value,
    output logic over_dash,
    output logic under_dash,
    output logic [2:0] dash_count,
    output logic [39:0] segment_lit,
    output logic lead_one_digit5,
    output logic lead_one_digit4
);
    import lcd_range_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // merge byte lanes of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge16

    function automatic bank_state_t reset_state(input bit full);
        bank_state_t s;
        s = '0;
        s.wait_q = 1'b1;
        s.over_thr = full ? OVER_RST_45 : OVER_RST_35;
        s.under_thr = full ? UNDER_RST_45 : UNDER_RST_35;
        s.disp_word = WORD_RST;
        s.seg_low = SEG16_RST;
        s.seg_mid = SEG16_RST;
        s.seg_high = SEG8_RST;
        s.src = SRC_LIVE;
        return s;
    endfunction : reset_state

    localparam bank_state_t RESET_STATE = reset_state(FULL_DIGIT5);

    bank_state_t state_reg;
    bank_state_t state_next;

    logic req;
    logic accept;
    logic status_rd;
    logic over_now;
    logic under_now;
    logic [31:0] rd_mux;
    logic [39:0] lit_raw;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: request is accepted on the cycle waitrequest is low

    assign req = read | write;
    assign accept = req & ~state_reg.wait_q;
    assign status_rd = accept & read & (address == ADDR_STATUS);

    // signed compare of a fresh result; only valid results count
    assign over_now = conv.valid & ($signed(conv.value) > $signed(state_reg.over_thr));
    assign under_now = conv.valid & ($signed(conv.value) < $signed(state_reg.under_thr));

    // read mux, narrow registers sit in the low bits
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (address)
            ADDR_CONTROL: begin
                rd_mux[CTL_SEG_DIRECT] = state_reg.seg_dir;
                rd_mux[CTL_HOST_SRC] = state_reg.host_src;
                rd_mux[CTL_FREEZE] = state_reg.freeze;
                rd_mux[CTL_PEAK] = state_reg.peak_mode;
            end
            ADDR_STATUS: begin
                rd_mux[STS_OVER_FLAG] = state_reg.over_flag;
                rd_mux[STS_UNDER_FLAG] = state_reg.under_flag;
                rd_mux[STS_OVER_COND] = state_reg.over_cond;
                rd_mux[STS_UNDER_COND] = state_reg.under_cond;
            end
            ADDR_OVER_THR: rd_mux[15:0] = state_reg.over_thr;
            ADDR_UNDER_THR: rd_mux[15:0] = state_reg.under_thr;
            ADDR_DISP_WORD: rd_mux[15:0] = state_reg.disp_word;
            ADDR_SEG_LOW: rd_mux[15:0] = state_reg.seg_low;
            ADDR_SEG_MID: rd_mux[15:0] = state_reg.seg_mid;
            ADDR_SEG_HIGH: rd_mux[7:0] = state_reg.seg_high;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // segment drive is inverted: a stored 0 lights the segment
    assign lit_raw = ~{state_reg.seg_high, state_reg.seg_mid, state_reg.seg_low};

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        state_next = state_reg;
        // one wait cycle, then a single answer cycle
        state_next.wait_q = ~(req & state_reg.wait_q);
        if (req & state_reg.wait_q) begin
            state_next.rdata = read ? rd_mux : 32'h0000_0000;
        end

        // register writes land on the accepting edge
        if (accept & write) begin
            case (address)
                ADDR_CONTROL: begin
                    if (byteenable[0]) begin
                        state_next.seg_dir = writedata[CTL_SEG_DIRECT];
                        state_next.host_src = writedata[CTL_HOST_SRC];
                        state_next.freeze = writedata[CTL_FREEZE];
                        state_next.peak_mode = writedata[CTL_PEAK];
                    end
                end
                ADDR_OVER_THR: state_next.over_thr = merge16(state_reg.over_thr, writedata, byteenable);
                ADDR_UNDER_THR: state_next.under_thr = merge16(state_reg.under_thr, writedata, byteenable);
                ADDR_DISP_WORD: state_next.disp_word = merge16(state_reg.disp_word, writedata, byteenable);
                // bit 0 of the two wide segment registers has no segment behind it
                ADDR_SEG_LOW: state_next.seg_low = merge16(state_reg.seg_low, writedata, byteenable) & 16'hfffe;
                ADDR_SEG_MID: state_next.seg_mid = merge16(state_reg.seg_mid, writedata, byteenable) & 16'hfffe;
                ADDR_SEG_HIGH: begin
                    if (byteenable[0]) begin
                        state_next.seg_high = writedata[7:0];
                    end
                end
                default: state_next = state_next;
            endcase
        end

        // condition levels track the latest result only
        if (conv.valid) begin
            state_next.over_cond = over_now;
            state_next.under_cond = under_now;
        end

        // only bits the host actually saw are cleared, and never while the condition stands;
        // a new event in the same cycle wins over the clear
        if (status_rd) begin
            if (state_reg.rdata[STS_OVER_FLAG] & ~state_reg.over_cond) begin
                state_next.over_flag = 1'b0;
            end
            if (state_reg.rdata[STS_UNDER_FLAG] & ~state_reg.under_cond) begin
                state_next.under_flag = 1'b0;
            end
        end
        if (over_now) begin
            state_next.over_flag = 1'b1;
        end
        if (under_now) begin
            state_next.under_flag = 1'b1;
        end

        // display word follows results, or the peak value in peak mode, unless host, freeze or segment mode owns it
        if (!(accept & write & (address == ADDR_DISP_WORD))) begin
            if (!state_reg.seg_dir && !state_reg.host_src && !state_reg.freeze) begin
                if (state_reg.peak_mode) begin
                    state_next.disp_word = peak_value;
                end else if (conv.valid) begin
                    state_next.disp_word = conv.value;
                end
            end
        end

        // fixed source priority
        if (state_reg.seg_dir) begin
            state_next.src = SRC_SEG;
        end else if (state_reg.host_src) begin
            state_next.src = SRC_HOST;
        end else if (state_reg.freeze) begin
            state_next.src = SRC_FREEZE;
        end else if (state_reg.peak_mode) begin
            state_next.src = SRC_PEAK;
        end else begin
            state_next.src = SRC_LIVE;
        end
        state_next.shown = state_reg.seg_dir ? 16'h0000 : state_reg.disp_word;

        // limit dashes replace numeric display; segment mode is unaffected
        state_next.over_dash = ~state_reg.seg_dir & state_reg.over_cond;
        state_next.under_dash = ~state_reg.seg_dir & ~state_reg.over_cond & state_reg.under_cond;
        if (state_next.over_dash | state_next.under_dash) begin
            state_next.dashes = FULL_DIGIT5 ? DASHES_45 : DASHES_35;
        end else begin
            state_next.dashes = 3'h0;
        end

        // direct segment drive, digit 4 inert on the smaller variant
        if (state_reg.seg_dir) begin
            state_next.seg_lit = lit_raw & ~(FULL_DIGIT5 ? 40'h0 : DIGIT4_MASK);
            state_next.seg_lit[LEAD_ONE_BIT] = 1'b0;
            state_next.seg_lit[0] = 1'b0;
            state_next.seg_lit[16] = 1'b0;
            state_next.lead_one5 = FULL_DIGIT5 & lit_raw[LEAD_ONE_BIT];
            state_next.lead_one4 = ~FULL_DIGIT5 & lit_raw[LEAD_ONE_BIT];
        end else begin
            state_next.seg_lit = 40'h0;
            state_next.lead_one5 = 1'b0;
            state_next.lead_one4 = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign readdata = state_reg.rdata;
    assign waitrequest = state_reg.wait_q;
    assign display_source = state_reg.src;
    assign display_value = state_reg.shown;
    assign over_dash = state_reg.over_dash;
    assign under_dash = state_reg.under_dash;
    assign dash_count = state_reg.dashes;
    assign segment_lit = state_reg.seg_lit;
    assign lead_one_digit5 = state_reg.lead_one5;
    assign lead_one_digit4 = state_reg.lead_one4;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_prio_seg;
        state_reg.seg_dir |=> (display_source == SRC_SEG) && (display_value == 16'h0000);
    endproperty
    a_prio_seg: assert property (p_prio_seg) else $error("segment mode not selected");

    property p_prio_host;
        !state_reg.seg_dir && state_reg.host_src |=> display_source == SRC_HOST;
    endproperty
    a_prio_host: assert property (p_prio_host) else $error("host source not selected");

    // dashes only show while segment mode is off, so the dash follows the mode of the flag cycle
    property p_over_set;
        conv.valid && ($signed(conv.value) > $signed(state_reg.over_thr))
            |=> state_reg.over_flag ##1 (over_dash != $past(state_reg.seg_dir));
    endproperty
    a_over_set: assert property (p_over_set) else $error("over flag or dash missing");

    property p_under_set;
        conv.valid && ($signed(conv.value) < $signed(state_reg.under_thr)) |=> state_reg.under_flag;
    endproperty
    a_under_set: assert property (p_under_set) else $error("under flag not set");

    property p_seg_invert;
        state_reg.seg_dir |=> segment_lit[15:1] == ~$past(state_reg.seg_low[15:1]);
    endproperty
    a_seg_invert: assert property (p_seg_invert) else $error("segment polarity wrong");

    property p_freeze;
        state_reg.freeze && !(accept && write && address == ADDR_DISP_WORD) |=> $stable(state_reg.disp_word);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen display word changed");

    property p_rd_clear;
        status_rd && state_reg.rdata[STS_OVER_FLAG] && !state_reg.over_cond && !over_now
            |=> !state_reg.over_flag;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("over flag not cleared by read");

    property p_dash_count;
        state_reg.under_cond && !state_reg.over_cond && !state_reg.seg_dir
            |=> under_dash && dash_count == (FULL_DIGIT5 ? DASHES_45 : DASHES_35);
    endproperty
    a_dash_count: assert property (p_dash_count) else $error("under dash display wrong");

    property p_digit4_inert;
        !FULL_DIGIT5 |-> ((segment_lit & DIGIT4_MASK) == 40'h0) && !lead_one_digit5;
    endproperty
    a_digit4_inert: assert property (p_digit4_inert) else $error("digit 4 driven on small variant");

    property p_answer;
        req && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing wrong");

    property p_prio_freeze;
        !state_reg.seg_dir && !state_reg.host_src && state_reg.freeze |=> display_source == SRC_FREEZE;
    endproperty
    a_prio_freeze: assert property (p_prio_freeze) else $error("freeze source not selected");

    // peak only counts once segment, host and freeze are all off
    property p_prio_low;
        !state_reg.seg_dir && !state_reg.host_src && !state_reg.freeze
            |=> display_source == ($past(state_reg.peak_mode) ? SRC_PEAK : SRC_LIVE);
    endproperty
    a_prio_low: assert property (p_prio_low) else $error("peak or live source not selected");

    property p_over_dash;
        state_reg.over_cond && !state_reg.seg_dir
            |=> over_dash && !under_dash && dash_count == (FULL_DIGIT5 ? DASHES_45 : DASHES_35);
    endproperty
    a_over_dash: assert property (p_over_dash) else $error("over dash display wrong");

    property p_under_clear;
        status_rd && state_reg.rdata[STS_UNDER_FLAG] && !state_reg.under_cond && !under_now
            |=> !state_reg.under_flag;
    endproperty
    a_under_clear: assert property (p_under_clear) else $error("under flag not cleared by read");

    // a flag whose condition still stands survives the read that returns it
    property p_rd_keep;
        status_rd && state_reg.over_flag && state_reg.over_cond |=> state_reg.over_flag;
    endproperty
    a_rd_keep: assert property (p_rd_keep) else $error("standing over flag cleared");

    property p_lead_one;
        state_reg.seg_dir && lit_raw[LEAD_ONE_BIT]
            |=> lead_one_digit5 == FULL_DIGIT5 && lead_one_digit4 == !FULL_DIGIT5;
    endproperty
    a_lead_one: assert property (p_lead_one) else $error("leading one routed to wrong digit");

    property p_seg_off;
        !state_reg.seg_dir |=> segment_lit == 40'h0 && !lead_one_digit5 && !lead_one_digit4;
    endproperty
    a_seg_off: assert property (p_seg_off) else $error("segments driven outside segment mode");
endmodule : lcd_source_range_segment_regs

// ==== tb/conv_feed_model.sv ====
// Purpose: converter side model feeding conversion results and a peak register
// Assumes: one request pulse from the bench per conversion, same clock as the bank
// Notes: between results the value lines toggle so a stale word never looks valid
`timescale 1ns/1ps

module conv_feed_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic fire,
    input wire logic [15:0] sample,
    output lcd_range_pkg::conv_result_t conv,
    output logic [15:0] peak_value
);
    import lcd_range_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle result pulse; peak keeps the largest signed result seen
    always_ff @(posedge clock) begin
        if (srst) begin
            conv <= '0;
            peak_value <= 16'h8000; // most negative, so the first result always wins
        end else begin
            conv.valid <= fire;
            conv.value <= fire ? sample : ~conv.value;
            if (fire && ($signed(sample) > $signed(peak_value))) begin
                peak_value <= sample;
            end
        end
    end
endmodule : conv_feed_model

// ==== tb/lcd_source_range_segment_regs_test.sv ====
// Purpose: self-checking bench for the display source, range and segment register bank
// Assumes: 4.5-digit and 3.5-digit variants on shared inputs, Avalon-MM host, converter model on the result input
// Notes: expected values are worked out here from the register map and reset values
`timescale 1ns/1ps

module lcd_source_range_segment_regs_test;
    import lcd_range_pkg::*;

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic fire = 1'b0;
    logic [15:0] sample = 16'h0000;
    conv_result_t conv;
    logic [15:0] peak_value;
    disp_src_t display_source;
    logic [15:0] display_value;
    logic over_dash;
    logic under_dash;
    logic [2:0] dash_count;
    logic [39:0] segment_lit;
    logic lead_one_digit5;
    logic lead_one_digit4;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata_small;
    logic over_dash_small;
    logic under_dash_small;
    logic [2:0] dash_count_small;
    logic [39:0] segment_lit_small;
    logic lead_one_digit5_small;
    logic lead_one_digit4_small;
    logic [31:0] q_small = 32'h0;
    int num_errors = 0;
    int n_compared = 0;
    // value, first status read, second status read
    logic [23:0] cases [8] = '{24'h4e1f00, 24'h4e2055, 24'h000010, 24'hb1e000,
                               24'hb1dfaa, 24'h7fff75, 24'h8000ba, 24'h000120};

    ////////////////////////////////////////////////////////////////////////
    // clock and design under test
    always #2.5 clock = ~clock;

    lcd_source_range_segment_regs dut (.clock(clock), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .conv(conv), .peak_value(peak_value),
        .display_source(display_source), .display_value(display_value), .over_dash(over_dash),
        .under_dash(under_dash), .dash_count(dash_count), .segment_lit(segment_lit),
        .lead_one_digit5(lead_one_digit5), .lead_one_digit4(lead_one_digit4));

    // smaller variant shares every input, so only its own outputs need watching
    lcd_source_range_segment_regs #(.FULL_DIGIT5(1'b0)) dut_small (.clock(clock), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata_small),
        .waitrequest(), .conv(conv), .peak_value(peak_value), .display_source(), .display_value(),
        .over_dash(over_dash_small), .under_dash(under_dash_small), .dash_count(dash_count_small),
        .segment_lit(segment_lit_small), .lead_one_digit5(lead_one_digit5_small),
        .lead_one_digit4(lead_one_digit4_small));

    conv_feed_model feed (.clock(clock), .srst(srst), .fire(fire), .sample(sample), .conv(conv),
        .peak_value(peak_value));

    ////////////////////////////////////////////////////////////////////////
    // verdict, comparison and bus tasks
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // request held until waitrequest is sampled low; bounded so a dead slave ends the run
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= {16'h0000, d};
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        q_small = readdata_small;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, waitrequest, 1'b0);
            finish_test();
        end
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        repeat (3) @(posedge clock);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        check(40'(q), 40'(e));
    endtask : rd_chk

    // one result pulse, then room for flags and dash outputs to land
    task automatic convert(input logic [15:0] v);
        @(posedge clock);
        fire <= 1'b1;
        sample <= v;
        @(posedge clock);
        fire <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : convert

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [3:0] c;
        disp_src_t e;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        // reset values of the threshold, segment and status registers
        check(40'(display_source), 40'(SRC_LIVE));
        rd_chk(ADDR_OVER_THR, 32'h4e1f);
        check(40'(q_small), 40'h7cf0);
        rd_chk(ADDR_UNDER_THR, 32'hb1e0);
        check(40'(q_small), 40'h8300);
        rd_chk(ADDR_SEG_LOW, 32'h0);
        rd_chk(ADDR_SEG_MID, 32'h0);
        rd_chk(ADDR_SEG_HIGH, 32'h0);
        rd_chk(ADDR_STATUS, 32'h0);
        // segment mode straight after reset lights everything but the unused bits
        wr(ADDR_CONTROL, 16'h0001);
        check(segment_lit, 40'hdf_fffe_fffe);
        check(40'(lead_one_digit5), 40'h1);
        check(segment_lit_small, 40'hc0_1ffe_fffe);
        check(40'(lead_one_digit4_small), 40'h1);
        check(40'(lead_one_digit5_small), 40'h0);
        check(40'(display_value), 40'h0);
        // written patterns read back with bit 0 and upper bits forced to zero
        wr(ADDR_SEG_LOW, 16'h5a5b);
        wr(ADDR_SEG_MID, 16'h0ff1);
        wr(ADDR_SEG_HIGH, 16'h01d6);
        rd_chk(ADDR_SEG_LOW, 32'h5a5a);
        rd_chk(ADDR_SEG_MID, 32'h0ff0);
        rd_chk(ADDR_SEG_HIGH, 32'hd6);
        check(segment_lit, ~{8'hd6, 16'h0ff0, 16'h5a5a} & 40'hdf_fffe_fffe);
        wr(ADDR_SEG_HIGH, 16'h00f6);
        check(40'(lead_one_digit5), 40'h0);
        check(40'(lead_one_digit4), 40'h0);
        check(segment_lit, ~{8'hf6, 16'h0ff0, 16'h5a5a} & 40'hdf_fffe_fffe);
        check(segment_lit_small, ~{8'hf6, 16'h0ff0, 16'h5a5a} & 40'hc0_1ffe_fffe);
        check(40'(lead_one_digit4_small), 40'h0);
        // every control combination against the fixed source priority
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            e = c[0] ? SRC_SEG : c[1] ? SRC_HOST : c[2] ? SRC_FREEZE : c[3] ? SRC_PEAK : SRC_LIVE;
            wr(ADDR_CONTROL, {12'h000, c});
            check(40'(display_source), 40'(e));
        end
        // live, freeze, host and peak sources in turn
        wr(ADDR_CONTROL, 16'h0000);
        convert(16'h0064);
        check(40'(display_value), 40'h64);
        wr(ADDR_CONTROL, 16'h0004);
        convert(16'h00c8);
        check(40'(display_value), 40'h64);
        wr(ADDR_CONTROL, 16'h0002);
        wr(ADDR_DISP_WORD, 16'h1234);
        check(40'(display_value), 40'h1234);
        wr(ADDR_CONTROL, 16'h0008);
        check(40'(display_value), 40'hc8);
        wr(ADDR_CONTROL, 16'h0001);
        check(40'(display_value), 40'h0);
        // limit table: boundaries, signed extremes, latched flags and read clearing
        wr(ADDR_CONTROL, 16'h0000);
        foreach (cases[k]) begin
            convert(cases[k][23:8]);
            check(40'(over_dash), 40'(cases[k][6]));
            check(40'(under_dash), 40'(cases[k][7] & ~cases[k][6]));
            check(40'(dash_count), (cases[k][7] | cases[k][6]) ? 40'h4 : 40'h0);
            rd_chk(ADDR_STATUS, {28'h0, cases[k][7:4]});
            rd_chk(ADDR_STATUS, {28'h0, cases[k][3:0]});
        end
        // a single upper lane write leaves the low byte alone
        byteenable <= 4'h2;
        wr(ADDR_OVER_THR, 16'h00aa);
        byteenable <= 4'hf;
        rd_chk(ADDR_OVER_THR, 32'h001f);
        check(40'(q_small), 40'h00f0);
        // moved thresholds are honoured and read back
        wr(ADDR_OVER_THR, 16'h0010);
        wr(ADDR_UNDER_THR, 16'hfff0);
        rd_chk(ADDR_OVER_THR, 32'h0010);
        rd_chk(ADDR_UNDER_THR, 32'hfff0);
        convert(16'h0011);
        check(40'(over_dash), 40'h1);
        check(40'(dash_count_small), 40'h3);
        convert(16'hffef);
        check(40'(under_dash), 40'h1);
        check(40'(under_dash_small), 40'h1);
        check(40'(dash_count_small), 40'h3);
        rd_chk(ADDR_STATUS, 32'h0b);
        check(40'(q_small), 40'h0b);
        finish_test();
    end
endmodule : lcd_source_range_segment_regs_test
